// ---- hdl/reb_pkg.sv ----
// Package: constants, types and thresholds for the receive elastic buffer
package reb_pkg;

	// One decoded character per entry: control flag plus byte
	typedef struct packed {
		logic       is_k;
		logic [7:0] data;
	} reb_char_s;

	// Buffer variant selection
	typedef enum logic [1:0] {
		REB_V_XCVR   = 2'b00,
		REB_V_FABRIC = 2'b01,
		REB_V_TBI    = 2'b10
	} reb_variant_e;

	// Decoded code-group values
	localparam logic [7:0] REB_K28_5 = 8'hBC;
	localparam logic [7:0] REB_D16_2 = 8'h50;

	// Depth of the single physical store (largest variant)
	localparam int REB_ADDR_W = 7;
	localparam int REB_DEPTH  = 128;
	localparam int REB_LVL_W  = 8;

	// Fabric / SGMII variant
	localparam logic [7:0] REB_FAB_HALF  = 8'h40;
	localparam logic [7:0] REB_FAB_OVER  = 8'h7A;
	localparam logic [7:0] REB_FAB_UNDER = 8'h06;
	// Ten-bit interface 1000BASE-X variant
	localparam logic [7:0] REB_TBI_HALF  = 8'h10;
	localparam logic [7:0] REB_TBI_OVER  = 8'h1E;
	localparam logic [7:0] REB_TBI_UNDER = 8'h02;
	// Transceiver-internal variant
	localparam logic [7:0] REB_XCV_HALF  = 8'h20;
	localparam logic [7:0] REB_XCV_OVER  = 8'h3D;
	localparam logic [7:0] REB_XCV_UNDER = 8'h08;

	// Uncertainty band around half full, in entries
	localparam logic [7:0] REB_HYST = 8'h02;

	// Tolerance figures: 100 ppm each side gives one slip in 5000 periods
	localparam int REB_PPM_EACH    = 100;
	localparam int REB_SLIP_PERIOD = 1_000_000 / (2 * REB_PPM_EACH);

	// Minimum /I2/ kept in a gap at 100 Mb/s and byte repeat count
	localparam int REB_MIN_I2_100M = 20;
	localparam int REB_REPEAT_100M = 10;

	// Reset values
	localparam logic [REB_ADDR_W-1:0] REB_PTR_RST = 7'h00;

	// Gray encode and decode of pointers
	function automatic logic [REB_ADDR_W-1:0] reb_bin2gray(input logic [REB_ADDR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [REB_ADDR_W-1:0] reb_gray2bin(input logic [REB_ADDR_W-1:0] g);
		logic [REB_ADDR_W-1:0] b;
		b = '0;
		for (int i = REB_ADDR_W - 1; i >= 0; i--) begin
			b[i] = g[i] ^ ((i == REB_ADDR_W - 1) ? 1'b0 : b[i+1]);
		end
		return b;
	endfunction

endpackage

// ---- hdl/reb_mem.sv ----
// Dual-port character store with registered read data
`timescale 1ns/100ps
module reb_mem
	import reb_pkg::*;
#(
	parameter int AW = REB_ADDR_W
) (
	// Clock
	input  wire logic            clk,
	// Write port
	input  wire logic            wr_en,
	input  wire logic [AW-1:0]   wr_addr,
	input  reb_pkg::reb_char_s   wr_data,
	// Read port
	input  wire logic [AW-1:0]   rd_addr,
	output reb_pkg::reb_char_s   rd_data
);
	import reb_pkg::*;

	reb_char_s store [0:(1<<AW)-1];

	// Write and registered read; no reset on the array itself
	always_ff @(posedge clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
		rd_data <= store[rd_addr];
	end

endmodule

// ---- hdl/reb_sync.sv ----
// Two-flop synchroniser for a bus of levels
`timescale 1ns/100ps
module reb_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

// ---- hdl/reb_top.sv ----
// Receive elastic buffer with idle-pair clock correction
// Behaviour
// - Rate offset is absorbed only between frames, by adding or dropping idles.
// - Each gap steers the fill level back toward the half-full mark.
// - Every entry holds one decoded character, one byte plus its control flag.
// - The fabric variant uses half 64, overflow 122 and underflow 6.
// - The ten-bit 1000BASE-X variant uses half 16, overflow 30 and underflow 2.
// - The transceiver variant uses half 32, overflow 61 and underflow 8.
// - Ten-bit traffic in SGMII or switching mode takes the fabric thresholds.
// - Only whole /I2/ pairs are added or dropped, never /T/, /R/ or /I1/.
// - A low buffer repeats idle pairs after an /I2/ with no limit until half full; an empty one stalls out_valid.
// - At 100 Mb/s the design leaves at least 20 /I2/ in a gap removable.
// - At 100 Mb/s each byte shows ten times and passes untouched here.
// - The depth tolerates one slip per 5000 periods of 125 MHz.
// - The crossed fill level may be two entries off the midpoint.
// - An /I2/ is the comma even then D16.2 odd, handled as one pair.
`timescale 1ns/100ps
module reb_top
	import reb_pkg::*;
#(
	parameter reb_pkg::reb_variant_e VARIANT = REB_V_FABRIC
) (
	// Core clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Mode: ten-bit interface carrying SGMII or dynamic switching
	input  wire logic               tbi_sgmii_mode,
	// Link side, from the code-group receiver
	input  wire logic               link_clk,
	input  wire logic               link_valid,
	input  reb_pkg::reb_char_s      link_char,
	// Core side, to the PCS receive engine
	output reb_pkg::reb_char_s      out_char,
	output logic                    out_valid,
	// Sticky errors, cleared by reset or err_clear, and the fill level
	input  wire logic               err_clear,
	output logic                    err_over,
	output logic                    err_under,
	output logic [REB_LVL_W-1:0]    fill_level
);
	import reb_pkg::*;

	// Link inputs sampled twice before any logic looks at them
	logic [10:0] link_raw;
	logic [10:0] link_s;
	assign link_raw = {link_clk, link_valid, link_char};

	reb_sync #(.W(11)) u_in_sync (
		.clk (clk),
		.rst (rst),
		.d   (link_raw),
		.q   (link_s)
	);

	logic      lclk_s;
	logic      lvalid_s;
	reb_char_s lchar_s;
	assign lclk_s   = link_s[10];
	assign lvalid_s = link_s[9];
	assign lchar_s  = reb_char_s'(link_s[8:0]);

	// Link clock edge detect, data captured one stage later
	logic      lclk_d;
	logic      lclk_rise;
	reb_char_s cap_char;
	logic      cap_valid;
	logic      cap_stb;
	logic      next_lclk_d;
	reb_char_s next_cap_char;
	logic      next_cap_valid;
	logic      next_cap_stb;

	assign lclk_rise = lclk_s & ~lclk_d;

	always_comb begin
		next_lclk_d    = lclk_s;
		next_cap_stb   = lclk_rise;
		next_cap_valid = lclk_rise ? lvalid_s : cap_valid;
		next_cap_char  = lclk_rise ? lchar_s : cap_char;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lclk_d    <= 1'b0;
			cap_stb   <= 1'b0;
			cap_valid <= 1'b0;
			cap_char  <= '0;
		end else begin
			lclk_d    <= next_lclk_d;
			cap_stb   <= next_cap_stb;
			cap_valid <= next_cap_valid;
			cap_char  <= next_cap_char;
		end
	end

	// Thresholds by variant; ten-bit SGMII borrows the fabric set
	logic [7:0] th_half;
	logic [7:0] th_over;
	logic [7:0] th_under;

	always_comb begin
		case (VARIANT)
			REB_V_XCVR: begin
				th_half  = REB_XCV_HALF;
				th_over  = REB_XCV_OVER;
				th_under = REB_XCV_UNDER;
			end
			REB_V_TBI: begin
				if (tbi_sgmii_mode) begin
					th_half  = REB_FAB_HALF;
					th_over  = REB_FAB_OVER;
					th_under = REB_FAB_UNDER;
				end else begin
					th_half  = REB_TBI_HALF;
					th_over  = REB_TBI_OVER;
					th_under = REB_TBI_UNDER;
				end
			end
			default: begin
				th_half  = REB_FAB_HALF;
				th_over  = REB_FAB_OVER;
				th_under = REB_FAB_UNDER;
			end
		endcase
	end

	// Write side: pair /I2/ characters so they can be dropped whole
	logic                  wr_en;
	logic [REB_ADDR_W-1:0] wr_ptr;
	logic [REB_ADDR_W-1:0] next_wr_ptr;
	reb_char_s             held;
	reb_char_s             next_held;
	logic                  held_k;
	logic                  next_held_k;
	logic                  drop_pair;
	logic                  is_comma;
	logic                  is_d162;
	logic [7:0]            level;
	logic                  wr_char_en;
	reb_char_s             wr_char;

	assign is_comma = cap_char.is_k && cap_char.data == REB_K28_5;
	assign is_d162  = !cap_char.is_k && cap_char.data == REB_D16_2;

	// A comma is held one character; if D16.2 follows and the buffer is high
	// the pair is dropped, else both go in order, so /I1/ is never touched
	always_comb begin
		next_held   = held;
		next_held_k = held_k;
		drop_pair   = 1'b0;
		wr_char_en  = 1'b0;
		wr_char     = cap_char;
		if (cap_stb && cap_valid) begin
			if (held_k) begin
				if (is_d162 && level > th_half + REB_HYST) begin
					drop_pair   = 1'b1;
					next_held_k = 1'b0;
				end else begin
					wr_char_en  = 1'b1;
					wr_char     = held;
					next_held   = cap_char;
					next_held_k = is_comma;
				end
			end else if (is_comma) begin
				next_held   = cap_char;
				next_held_k = 1'b1;
			end else begin
				wr_char_en = 1'b1;
			end
		end
	end

	// A non-comma after a held comma is written a cycle later from pend
	logic flush;
	assign flush = cap_stb && cap_valid && held_k && !drop_pair && !is_comma;
	reb_char_s pend;
	logic      pend_v;
	logic      next_pend_v;
	reb_char_s next_pend;

	always_comb begin
		next_pend_v = flush;
		next_pend   = flush ? cap_char : pend;
		next_wr_ptr = wr_ptr + REB_ADDR_W'(wr_char_en) + REB_ADDR_W'(pend_v);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held   <= '0;
			held_k <= 1'b0;
			pend   <= '0;
			pend_v <= 1'b0;
			wr_ptr <= REB_PTR_RST;
		end else begin
			held   <= next_held;
			held_k <= next_held_k;
			pend   <= next_pend;
			pend_v <= next_pend_v;
			wr_ptr <= next_wr_ptr;
		end
	end

	// One write per cycle: the new char wins, the pending flush is not written
	assign wr_en = wr_char_en | pend_v;
	reb_char_s mem_wdata;
	logic [REB_ADDR_W-1:0] mem_waddr;
	assign mem_wdata = wr_char_en ? wr_char : pend;
	assign mem_waddr = wr_ptr;

	// Read side: steady draining, idle pairs repeated when low
	logic [REB_ADDR_W-1:0] rd_ptr;
	logic [REB_ADDR_W-1:0] next_rd_ptr;
	logic                  rep_odd;
	logic                  next_rep_odd;
	logic                  repeating;
	logic                  next_repeating;
	reb_char_s             mem_q;
	reb_char_s             next_out_char;
	logic                  next_out_valid;
	logic                  last_was_comma;
	logic                  next_last_was_comma;

	reb_mem #(.AW(REB_ADDR_W)) u_mem (
		.clk     (clk),
		.wr_en   (wr_en),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (next_rd_ptr),   // Look-ahead, so mem_q shows the entry at rd_ptr
		.rd_data (mem_q)
	);

	// Read stalls on a completed /I2/ when below the band and emits extra pairs until half full
	always_comb begin
		next_rd_ptr         = rd_ptr;
		next_rep_odd        = rep_odd;
		next_repeating      = repeating;
		next_out_char       = mem_q;
		next_out_valid      = 1'b1;
		next_last_was_comma = mem_q.is_k && mem_q.data == REB_K28_5;
		if (repeating) begin
			next_out_char       = rep_odd ? reb_char_s'({1'b0, REB_D16_2})
			                              : reb_char_s'({1'b1, REB_K28_5});
			next_rep_odd        = ~rep_odd;
			next_last_was_comma = ~rep_odd;
			if (rep_odd && level + REB_HYST >= th_half) begin
				next_repeating = 1'b0;
			end
		end else if (level == 8'h00) begin
			next_out_valid      = 1'b0;
			next_last_was_comma = last_was_comma;   // A stall must not split a pair
		end else begin
			next_rd_ptr = rd_ptr + REB_ADDR_W'(1);
			if (last_was_comma && !mem_q.is_k && mem_q.data == REB_D16_2
			    && level + REB_HYST < th_half) begin
				next_repeating = 1'b1;
				next_rep_odd   = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_ptr         <= REB_PTR_RST;
			rep_odd        <= 1'b0;
			repeating      <= 1'b0;
			out_char       <= '0;
			out_valid      <= 1'b0;
			last_was_comma <= 1'b0;
		end else begin
			rd_ptr         <= next_rd_ptr;
			rep_odd        <= next_rep_odd;
			repeating      <= next_repeating;
			out_char       <= next_out_char;
			out_valid      <= next_out_valid;
			last_was_comma <= next_last_was_comma;
		end
	end

	// Occupancy; both pointers share clk so no gray crossing is needed here,
	// the band of two entries covers the link-sampling jitter.
	// Counts only entries already visible at the read port, so the empty test
	// never lets a slot be read in the cycle it is written
	logic [7:0] next_level;
	always_comb begin
		next_level = 8'(REB_ADDR_W'(wr_ptr - next_rd_ptr));
	end

	// Sticky errors, a new event wins over a clear in the same cycle
	logic next_err_over;
	logic next_err_under;
	always_comb begin
		next_err_over  = err_over;
		next_err_under = err_under;
		if (err_clear) begin
			next_err_over  = 1'b0;
			next_err_under = 1'b0;
		end
		if (level >= th_over) begin
			next_err_over = 1'b1;
		end
		if (out_valid && level <= th_under && level != 8'h00 && !repeating) begin
			next_err_under = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level     <= 8'h00;
			err_over  <= 1'b0;
			err_under <= 1'b0;
		end else begin
			level     <= next_level;
			err_over  <= next_err_over;
			err_under <= next_err_under;
		end
	end

	assign fill_level = level;

endmodule

// ---- verification/reb_top_checker.sv ----
// Port assertions for the receive elastic buffer
`timescale 1ns/100ps
module reb_top_checker
	import reb_pkg::*;
#(
	parameter reb_pkg::reb_variant_e VARIANT = REB_V_FABRIC
) (
	// Core clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Block inputs
	input  wire logic                 tbi_sgmii_mode,
	input  wire logic                 link_clk,
	input  wire logic                 link_valid,
	input  reb_pkg::reb_char_s        link_char,
	input  wire logic                 err_clear,
	// Block outputs
	input  reb_pkg::reb_char_s        out_char,
	input  wire logic                 out_valid,
	input  wire logic                 err_over,
	input  wire logic                 err_under,
	input  wire logic [REB_LVL_W-1:0] fill_level
);
	logic [7:0] lim_over, lim_under, lim_half;
	logic [3:0] since_edge, next_since_edge;
	logic       after_comma, next_after_comma, prev_link, next_prev_link;

	// Variant thresholds; ten-bit SGMII traffic borrows the fabric set
	always_comb begin
		lim_over  = REB_FAB_OVER;
		lim_under = REB_FAB_UNDER;
		lim_half  = REB_FAB_HALF;
		if (VARIANT == REB_V_XCVR) begin
			lim_over  = REB_XCV_OVER;
			lim_under = REB_XCV_UNDER;
			lim_half  = REB_XCV_HALF;
		end else if (VARIANT == REB_V_TBI && !tbi_sgmii_mode) begin
			lim_over  = REB_TBI_OVER;
			lim_under = REB_TBI_UNDER;
			lim_half  = REB_TBI_HALF;
		end
	end

	// Age of the last raw link edge; saturates so a stopped link is harmless
	always_comb begin
		next_prev_link   = link_clk;
		next_since_edge  = (link_clk && !prev_link) ? 4'h0 : since_edge + {3'h0, since_edge != 4'hF};
		next_after_comma = out_valid ? (out_char.is_k && out_char.data == REB_K28_5) : after_comma;
	end

	// Helper registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_link   <= 1'b0;
			since_edge  <= 4'hF;
			after_comma <= 1'b0;
		end else begin
			prev_link   <= next_prev_link;
			since_edge  <= next_since_edge;
			after_comma <= next_after_comma;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Idle set in two steps: the comma, then its odd half
	sequence comma_sent;
		after_comma && out_valid;
	endsequence
	sequence pair_closed;
		!out_char.is_k && (out_char.data == REB_D16_2 || out_char.data == 8'hC5);
	endsequence

	pair_order_a:
		assert property (comma_sent |-> pair_closed) else $error("comma left without its odd half");
	over_sticky_a:
		assert property (err_over && !err_clear |=> err_over) else $error("overflow flag lost");
	under_sticky_a:
		assert property (err_under && !err_clear |=> err_under) else $error("underflow flag lost");
	over_cause_a:
		assert property ($rose(err_over) |-> $past(fill_level) >= lim_over ||
			$past(fill_level, 2) >= lim_over) else $error("overflow flag without full level");
	under_cause_a:
		assert property ($rose(err_under) |-> $past(fill_level) <= lim_under ||
			$past(fill_level, 2) <= lim_under) else $error("underflow flag without low level");
	half_cap_a:
		assert property (fill_level <= lim_half + REB_HYST + 8'h02) else $error("level past half");
	fill_step_a:
		assert property (fill_level <= $past(fill_level) + 8'h02 &&
			fill_level + 8'h01 >= $past(fill_level)) else $error("level jumped");
	rise_timing_a:
		assert property (fill_level > $past(fill_level) |-> since_edge >= 4'h2 &&
			since_edge <= 4'h9) else $error("write not tied to a link edge");
endmodule

bind reb_top reb_top_checker #(.VARIANT(VARIANT)) u_checker (
	.clk(clk), .rst(rst), .tbi_sgmii_mode(tbi_sgmii_mode), .link_clk(link_clk),
	.link_valid(link_valid), .link_char(link_char), .err_clear(err_clear),
	.out_char(out_char), .out_valid(out_valid), .err_over(err_over),
	.err_under(err_under), .fill_level(fill_level)
);

// ---- verification/reb_link_src.sv ----
// Link-side character source with its own link clock
`timescale 1ns/100ps
module reb_link_src
	import reb_pkg::*;
(
	// Reset
	input  wire logic          rst,
	// Link outputs
	output logic               link_clk,
	output logic               link_valid,
	output reb_pkg::reb_char_s link_char
);
	reb_char_s q[$];

	initial begin
		link_clk   = 1'b0;
		link_valid = 1'b0;
		link_char  = '0;
	end

	// Recovered clock runs free: gaps travel as characters
	always #62.5 link_clk = ~link_clk;

	// New character on the falling edge, steady around the rising one
	always @(negedge link_clk) begin
		if (rst) begin
			link_valid <= 1'b0;
			link_char  <= ~link_char;
		end else begin
			if (q.size() == 0) begin
				q.push_back('{1'b1, REB_K28_5});
				q.push_back('{1'b0, REB_D16_2});
			end
			link_valid <= 1'b1;
			link_char  <= q.pop_front();
		end
	end

	// Whole frames are queued at once so idle pairs never split
	task automatic send(input reb_char_s c);
		q.push_back(c);
	endtask
endmodule

// ---- verification/reb_top_bench.sv ----
// Self-checking bench for the receive elastic buffer
`timescale 1ns/100ps
module reb_top_bench;
	import reb_pkg::*;
	localparam int TIMEOUT = 30000;
	logic                 clk, rst, tbi_sgmii_mode, err_clear, link_clk, link_valid;
	logic                 out_valid, err_over, err_under;
	reb_char_s            link_char, out_char;
	logic [REB_LVL_W-1:0] fill_level, max_fill, fill_level_t, max_fill_t;
	logic [31:0]          rng;
	reb_char_s            exp_q[$];
	int                   errors, num_checks, cycles;

	reb_top #(.VARIANT(REB_V_FABRIC)) u_dut (.clk(clk), .rst(rst), .tbi_sgmii_mode(tbi_sgmii_mode),
		.link_clk(link_clk), .link_valid(link_valid), .link_char(link_char), .out_char(out_char),
		.out_valid(out_valid), .err_clear(err_clear), .err_over(err_over),
		.err_under(err_under), .fill_level(fill_level));
	reb_link_src u_src (.rst(rst), .link_clk(link_clk), .link_valid(link_valid),
		.link_char(link_char));
	// Ten-bit variant on the same link; its mode input moves it to the fabric set
	reb_top #(.VARIANT(REB_V_TBI)) u_dut_tbi (.clk(clk), .rst(rst),
		.tbi_sgmii_mode(tbi_sgmii_mode), .link_clk(link_clk), .link_valid(link_valid),
		.link_char(link_char), .out_char(), .out_valid(), .err_clear(err_clear),
		.err_over(), .err_under(), .fill_level(fill_level_t));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic is_idle(input reb_char_s c);
		return (c.is_k && c.data == REB_K28_5) || (!c.is_k && c.data == REB_D16_2);
	endfunction

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One character to the link; idles are left out of the model
	task automatic put(input logic k, input logic [7:0] d);
		reb_char_s c;
		c = '{k, d};
		u_src.send(c);
		if (!is_idle(c)) exp_q.push_back(c);
	endtask

	// Frame of random bytes, repeated for slow rates, then end marks and a gap
	task automatic frame(input int len, input int rep, input int gap);
		int         n;
		logic [7:0] d;
		n = 2;
		put(1'b1, 8'hFB);
		for (int i = 0; i < len; i++) begin
			rng = xorshift(rng);
			d = rng[7:0];
			if (d == REB_D16_2 || d == REB_K28_5) d = d ^ 8'h01;
			for (int r = 0; r < rep; r++) put(1'b0, d);
			n += rep;
		end
		put(1'b1, 8'hFD);
		if (n % 2) put(1'b1, 8'hF7); // Keeps the following comma even
		put(1'b1, REB_K28_5);
		put(1'b0, 8'hC5);
		for (int i = 0; i < gap; i++) begin
			put(1'b1, REB_K28_5);
			put(1'b0, REB_D16_2);
		end
		while (exp_q.size() != 0) @(posedge clk);
		#1;
	endtask

	// Long idle run, then the peak level must sit in the half-full band
	task automatic steer(input string name);
		logic [7:0] half_t;
		half_t = tbi_sgmii_mode ? REB_FAB_HALF : REB_TBI_HALF;
		max_fill = '0;
		max_fill_t = '0;
		repeat (1500) @(posedge clk);
		#1;
		check(name, {8'h00, max_fill >= REB_FAB_HALF - REB_HYST}, 9'h001);
		check(name, {8'h00, max_fill <= REB_FAB_HALF + REB_HYST}, 9'h001);
		check(name, {8'h00, max_fill_t >= half_t - REB_HYST}, 9'h001);
		check(name, {8'h00, max_fill_t <= half_t + REB_HYST}, 9'h001);
	endtask

	// Non-idle characters must leave in order and unchanged; also the hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			errors++;
			finish_test();
		end
		if (!rst && fill_level > max_fill) max_fill = fill_level;
		if (!rst && fill_level_t > max_fill_t) max_fill_t = fill_level_t;
		if (!rst && out_valid === 1'b1 && !is_idle(out_char)) begin
			if (exp_q.size() == 0) check("surplus char", out_char, 9'h1FF);
			else check("out_char", out_char, exp_q.pop_front());
		end
	end

	initial begin
		rst = 1'b1;
		tbi_sgmii_mode = 1'b0;
		err_clear = 1'b0;
		rng = 32'd51;
		errors = 0;
		num_checks = 0;
		cycles = 0;
		max_fill = '0;
		repeat (12) @(posedge clk);
		#1;
		check("out_valid in reset", {8'h00, out_valid}, 9'h000);
		check("fill in reset", {1'b0, fill_level}, 9'h000);
		rst = 1'b0;
		steer("steered level after start");
		// Full-rate frame: the level drains far enough to flag underflow
		frame(40, 1, 4);
		check("err_under", {8'h00, err_under}, 9'h001);
		check("err_over", {8'h00, err_over}, 9'h000);
		steer("steered level after frame");
		@(posedge clk);
		// Clear while the level is high, so no drain can set the flag again at once
		while (fill_level < 8'h20) @(posedge clk);
		#1 err_clear = 1'b1;
		@(posedge clk);
		#1 err_clear = 1'b0;
		@(posedge clk);
		#1;
		check("err_under cleared", {8'h00, err_under}, 9'h000);
		// Slow rate: each byte ten times, gap with more than twenty idle sets;
		// the ten-bit instance now carries SGMII and takes the fabric set
		tbi_sgmii_mode = 1'b1;
		frame(6, REB_REPEAT_100M, REB_MIN_I2_100M + 4);
		steer("steered level after slow frame");
		for (int i = 0; i < 3; i++) begin
			rng = xorshift(rng);
			frame(1 + int'(rng[4:0]), 1, 4 + int'(rng[9:8]));
		end
		steer("steered level at end");
		finish_test();
	end
endmodule
